// ==== bench/cpu_boot_model.sv ====
// Behavioural boot-loader core: arms a command and issues the store.
`timescale 1ns/100ps
module cpu_boot_model (
  input wire logic i_clk,
  input wire logic i_ee_busy,
  output logic o_ctrl_wr,
  output logic [7:0] o_ctrl_wdata,
  output logic o_spm
);
  initial begin
    o_ctrl_wr = 1'b0;
    o_ctrl_wdata = 8'h00;
    o_spm = 1'b0;
  end
  // A gap of zero never stores; a gap above four stores too late on purpose.
  task automatic issue(input logic [7:0] cmd, input int gap);
    while (i_ee_busy) @(posedge i_clk);
    o_ctrl_wr <= 1'b1;
    o_ctrl_wdata <= cmd;
    @(posedge i_clk);
    o_ctrl_wr <= 1'b0;
    o_ctrl_wdata <= ~cmd;
    if (gap > 0) begin
      repeat (gap - 1) @(posedge i_clk);
      o_spm <= 1'b1;
      @(posedge i_clk);
      o_spm <= 1'b0;
    end
  endtask
endmodule

// ==== bench/flash_self_programming_sequencer_test.sv ====
// Self-checking bench for the flash self-programming sequencer.
`timescale 1ns/100ps
module flash_self_programming_sequencer_test;
  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] z;
    logic [15:0] r;
    logic [2:0] gap;
    logic [2:0] ex;
    logic [8:0] pg;
  } row_t;
  // The ex field holds erase pulse, write pulse and stall.
  // same page erased then written, one command per entry.
  row_t rows [5] = '{
    '{8'h03, 16'h0143, 16'h1234, 3'h1, 3'h4, 9'h002},
    '{8'h83, 16'hE000, 16'h0000, 3'h2, 3'h5, 9'h1C0},
    '{8'h01, 16'h0006, 16'hA55A, 3'h3, 3'h0, 9'h000},
    '{8'h05, 16'hE000, 16'hFFFF, 3'h4, 3'h3, 9'h1C0},
    '{8'h89, 16'h0001, 16'h00F3, 3'h1, 3'h0, 9'h000}
  };
  logic clk, rst, load_program_mem_instr, ee, ctrl_wr, spm, lpm_hi, lpm_ok, lpm_blk, fl_blk;
  logic erase, write, stall, irq;
  logic [7:0] wdata, status, z_hi, z_lo, r1, r0;
  logic [5:0] buf_idx, lock;
  logic [14:0] lpm_addr;
  logic [8:0] page;
  logic [15:0] buf_data;
  int n_mismatch = 0;
  int comparisons = 0;
  flash_self_prog_seq #(.PROG_CYCLES(20)) dut_u (
    .i_clk(clk), .i_rst(rst), .i_ctrl_wr(ctrl_wr), .i_ctrl_wdata(wdata),
    .o_self_prog_ctrl_status(status), .i_spm(spm), .i_z_hi(z_hi), .i_z_lo(z_lo),
    .i_r1(r1), .i_r0(r0), .i_lpm(load_program_mem_instr), .o_lpm_word_addr(lpm_addr), .o_lpm_byte_hi(lpm_hi),
    .o_lpm_valid(lpm_ok), .o_lpm_blocked(lpm_blk), .i_eeprom_write_busy(ee),
    .o_fuse_lock_read_block(fl_blk), .o_flash_erase(erase), .o_flash_write(write),
    .o_flash_page(page), .i_buf_rd_idx(buf_idx), .o_buf_rd_data(buf_data),
    .o_lock_bits(lock), .o_cpu_stall(stall), .o_prog_irq(irq)
  );
  cpu_boot_model cpu_u (
    .i_clk(clk), .i_ee_busy(ee), .o_ctrl_wr(ctrl_wr), .o_ctrl_wdata(wdata), .o_spm(spm)
  );
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 60 && status[0] !== 1'b0; k++) @(posedge clk);
    #1;
    check("done", 16'(status[5:0]), 16'h0000);
  endtask
  task automatic lpm_read(input logic [15:0] a, input logic blk);
    @(posedge clk);
    {z_hi, z_lo} <= a;
    load_program_mem_instr <= 1'b1;
    @(posedge clk);
    load_program_mem_instr <= 1'b0;
    #1;
    check("lpm addr", {lpm_addr, lpm_hi}, a);
    check("lpm block", 16'({lpm_ok, lpm_blk}), 16'({1'b1, blk}));
  endtask
  task automatic buf_check(input logic [15:0] exp);
    @(posedge clk);
    buf_idx <= 6'h03;
    repeat (2) @(posedge clk);
    #1;
    check("buffer", buf_data, exp);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    load_program_mem_instr = 1'b0;
    ee = 1'b0;
    {z_hi, z_lo, r1, r0} = 32'h0000_0000;
    buf_idx = 6'h00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("reset status", 16'(status), 16'h0000);
    check("reset lock", 16'(lock), 16'h003F);
    check("reset buffer", buf_data, 16'hFFFF);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      {z_hi, z_lo} <= rows[i].z;
      {r1, r0} <= rows[i].r;
      cpu_u.issue(rows[i].cmd, int'(rows[i].gap));
      #1;
      check("erase", 16'(erase), 16'(rows[i].ex[2]));
      check("write", 16'(write), 16'(rows[i].ex[1]));
      check("stall", 16'(stall), 16'(rows[i].ex[0]));
      check("busy", 16'(status[6]), 16'(|rows[i].ex[2:1]));
      wait_idle();
      check("stall end", 16'(stall), 16'h0000);
      if (rows[i].ex[2:1] != 2'b00) begin
        lpm_read(rows[i].ex[0] ? 16'hFFFF : 16'h0000, !rows[i].ex[0]);
        check("page", 16'(page), 16'(rows[i].pg));
        @(posedge clk);
        cpu_u.issue(8'h11, 1);
        @(posedge clk);
        #1;
        check("busy end", 16'(status[6]), 16'h0000);
      end
      buf_check(rows[i].cmd == 8'h01 ? 16'hA55A : 16'hFFFF);
    end
    check("lock bits", 16'(lock), 16'h0033);
    check("irq on", 16'(irq), 16'h0001);
    @(posedge clk);
    cpu_u.issue(8'h00, 0);
    @(posedge clk);
    #1;
    check("irq off", 16'(irq), 16'h0000);
    @(posedge clk);
    cpu_u.issue(8'h03, 5);
    #1;
    check("late store", 16'({erase, status[6]}), 16'h0000);
    check("expired", 16'(status[5:0]), 16'h0000);
    @(posedge clk);
    {z_hi, z_lo} <= 16'h0006;
    cpu_u.issue(8'h01, 1);
    @(posedge clk);
    fork
      cpu_u.issue(8'h03, 3);
      begin
        @(posedge clk);
        ee <= 1'b1;
      end
    join
    #1;
    check("ee erase", 16'({erase, status[6]}), 16'h0000);
    check("fuse block", 16'(fl_blk), 16'h0001);
    @(posedge clk);
    ee <= 1'b0;
    buf_check(16'hFFFF);
    // A word loaded just before a mid-run reset must not survive it.
    @(posedge clk);
    cpu_u.issue(8'h01, 1);
    buf_check(16'h00F3);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    buf_check(16'hFFFF);
    check("mid reset lock", 16'(lock), 16'h003F);
    wrap_up();
  end
endmodule

// ==== bench/flash_sp_checker.sv ====
// Port-level assertions for the flash self-programming sequencer.
`timescale 1ns/100ps
module flash_sp_checker #(
  parameter int WORD_BITS = 6,
  parameter int HALTING_SECTION_FIRST_PAGE = 448,
  parameter int PROG_CYCLES = 92500
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ctrl_wr,
  input wire logic [7:0] i_ctrl_wdata,
  input wire logic [7:0] o_self_prog_ctrl_status,
  input wire logic i_spm,
  input wire logic [7:0] i_z_hi,
  input wire logic [7:0] i_z_lo,
  input wire logic [7:0] i_r0,
  input wire logic i_lpm,
  input wire logic [14:0] o_lpm_word_addr,
  input wire logic o_lpm_byte_hi,
  input wire logic o_lpm_valid,
  input wire logic o_lpm_blocked,
  input wire logic i_eeprom_write_busy,
  input wire logic o_fuse_lock_read_block,
  input wire logic o_flash_erase,
  input wire logic o_flash_write,
  input wire logic [14-WORD_BITS:0] o_flash_page,
  input wire logic [5:0] o_lock_bits,
  input wire logic o_cpu_stall,
  input wire logic o_prog_irq
);
  logic [7:0] st;
  logic [15:0] z;
  logic go;
  logic run_q;
  logic run_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  assign st = o_self_prog_ctrl_status;
  assign z = {i_z_hi, i_z_lo};
  assign go = i_spm && !i_eeprom_write_busy;
  // Counts cycles since an erase or write began, so its length can be bounded.
  always_comb begin
    run_d = (run_q && st[0]) || o_flash_erase || o_flash_write;
    cnt_d = (o_flash_erase || o_flash_write) ? 32'h0 : cnt_q + 32'h1;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      run_q <= 1'b0;
      cnt_q <= 32'h0;
    end else begin
      run_q <= run_d;
      cnt_q <= cnt_d;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_ERASE_PAGE: assert property (
    go && st[5:0] == 6'h03 |=> o_flash_erase && o_flash_page == $past(z[15:WORD_BITS+1]))
    else $error("erase did not start on the addressed page");
  AST_WRITE_PAGE: assert property (
    go && st[5:0] == 6'h05 |=> o_flash_write && o_flash_page == $past(z[15:WORD_BITS+1]))
    else $error("write did not start on the addressed page");
  AST_STALL_BUSY: assert property (
    o_flash_erase || o_flash_write |-> st[6] && o_cpu_stall == (o_flash_page >= HALTING_SECTION_FIRST_PAGE))
    else $error("stall or busy flag wrong at start");
  AST_LOCK_AND: assert property (
    go && st[5:0] == 6'h09 |=> o_lock_bits == ($past(o_lock_bits) & $past(i_r0[5:0]))
      && !o_cpu_stall && !st[6])
    else $error("lock bits not programmed from data");
  AST_IRQ_LEVEL: assert property (
    o_prog_irq == (st[7] && !st[0]))
    else $error("interrupt level wrong");
  AST_LPM_ADDR: assert property (
    i_lpm |=> o_lpm_valid && {o_lpm_word_addr, o_lpm_byte_hi} == $past(z))
    else $error("read address wrong");
  AST_LPM_BLOCK: assert property (
    o_lpm_valid && st[6] && $past(st[6])
      |-> o_lpm_blocked == (o_lpm_word_addr[14:WORD_BITS] < HALTING_SECTION_FIRST_PAGE))
    else $error("read blocking wrong while busy");
  AST_EE_BLOCK: assert property (
    i_eeprom_write_busy |=> o_fuse_lock_read_block && !o_flash_erase && !o_flash_write)
    else $error("command or fuse read not blocked");
  AST_ARM_EXPIRE: assert property (
    i_ctrl_wr && i_ctrl_wdata[0] && st[5:0] == 6'h00 ##1 !i_spm [*4] |=> st[5:0] == 6'h00)
    else $error("armed command did not expire");
  AST_RUN_TIME: assert property (
    run_q |-> cnt_q <= PROG_CYCLES + 3 && (st[0] || cnt_q >= PROG_CYCLES - 1))
    else $error("operation length wrong");
endmodule

bind flash_self_prog_seq flash_sp_checker #(
  .WORD_BITS(WORD_BITS), .HALTING_SECTION_FIRST_PAGE(HALTING_SECTION_FIRST_PAGE), .PROG_CYCLES(PROG_CYCLES)
) chk_u (
  .i_clk, .i_rst, .i_ctrl_wr, .i_ctrl_wdata, .o_self_prog_ctrl_status, .i_spm, .i_z_hi,
  .i_z_lo, .i_r0, .i_lpm, .o_lpm_word_addr, .o_lpm_byte_hi, .o_lpm_valid, .o_lpm_blocked,
  .i_eeprom_write_busy, .o_fuse_lock_read_block, .o_flash_erase, .o_flash_write,
  .o_flash_page, .o_lock_bits, .o_cpu_stall, .o_prog_irq
);

// ==== hw/flash_self_prog_seq.sv ====
// Flash self-programming sequencer: command arming, execution and status.
//
// Notes on behaviour
// - Command address comes from the 16-bit pointer, high byte over low byte.
// - Low pointer bits pick the word in page, high bits pick the page.
// - Target page is latched at start; later pointer changes do not matter.
// - Lock-bit programming ignores the pointer entirely.
// - Program-memory reads are byte addressed; pointer bit 0 picks the byte.
// - Pattern X0000011 then store within four cycles erases the addressed page.
// - Erase of read-while-write part keeps halting part readable; else CPU stalls.
// - Pattern 00000001 then store loads the data word into the page buffer.
// - Buffer clears after page write, on read re-enable, and on reset.
// - An EEPROM write during buffer loading discards all loaded words.
// - Pattern X0000101 then store writes the page; data registers are ignored.
// - Write to read-while-write part keeps halting part readable; else CPU stalls.
// - With interrupt enabled, interrupt is high while the enable bit is clear.
// - Erase or write blocks read-while-write reads and holds the busy flag.
// - Read re-enable clears the busy flag; software does it before reuse.
// - Pattern X0001001 then store programs each lock bit whose data bit is zero.
// - Lock programming leaves the whole flash readable with no stall.
// - An EEPROM write blocks all commands and fuse or lock reads.
// - Erase, write and lock operations each last between 3.7 ms and 4.5 ms.
// - A lock bit at one is unprogrammed; zero is programmed.
`timescale 1ns/100ps
`include "flash_sp_consts.svh"
module flash_self_prog_seq
  import flash_sp_pkg::*;
#(
  parameter int WORD_BITS = `WORD_BITS,
  parameter int HALTING_SECTION_FIRST_PAGE = `HALTING_SECTION_FIRST_PAGE,
  parameter int PROG_CYCLES = `PROG_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ctrl_wr,
  input wire logic [7:0] i_ctrl_wdata,
  output logic [7:0] o_self_prog_ctrl_status,
  input wire logic i_spm,
  input wire logic [7:0] i_z_hi,
  input wire logic [7:0] i_z_lo,
  input wire logic [7:0] i_r1,
  input wire logic [7:0] i_r0,
  input wire logic i_lpm,
  output logic [14:0] o_lpm_word_addr,
  output logic o_lpm_byte_hi,
  output logic o_lpm_valid,
  output logic o_lpm_blocked,
  input wire logic i_eeprom_write_busy,
  output logic o_fuse_lock_read_block,
  output logic o_flash_erase,
  output logic o_flash_write,
  output logic [14-WORD_BITS:0] o_flash_page,
  input wire logic [WORD_BITS-1:0] i_buf_rd_idx,
  output logic [15:0] o_buf_rd_data,
  output logic [`LOCK_W-1:0] o_lock_bits,
  output logic o_cpu_stall,
  output logic o_prog_irq
);
  localparam int PAGE_W = 15 - WORD_BITS;

  flash_sp_if #(.WORD_BITS(WORD_BITS)) sif ();

  flash_sp_page_buf #(.WORD_BITS(WORD_BITS)) u_buf (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .bif(sif.pbuf)
  );

  flash_sp_timer #(.PROG_CYCLES(PROG_CYCLES)) u_tmr (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .tif(sif.tmr)
  );

  // Pointer decode.
  logic [15:0] z_ptr;
  logic [PAGE_W-1:0] z_page;
  logic [WORD_BITS-1:0] z_word;
  assign z_ptr = {i_z_hi, i_z_lo};
  assign z_page = z_ptr[15:WORD_BITS+1];
  assign z_word = z_ptr[WORD_BITS:1];

  // Sequencer state.
  // Every output below is registered; the d values are built in the one process below.
  seq_state_t state_q, state_d;
  logic [`CMD_W-1:0] cmd_q, cmd_d;
  logic [2:0] arm_cnt_q, arm_cnt_d;
  op_kind_t op_q, op_d;
  logic [PAGE_W-1:0] page_q, page_d;
  logic ie_q, ie_d;
  logic busy_q, busy_d;
  logic stall_q, stall_d;
  logic erase_q, erase_d;
  logic write_q, write_d;
  logic [`LOCK_W-1:0] lock_q, lock_d;
  logic irq_q, irq_d;
  logic [7:0] status_q, status_d;
  logic buf_load;
  logic buf_clear;
  logic tmr_start;
  logic halting_target;

  // The page field alone picks the section: pages from HALTING_SECTION_FIRST_PAGE up form the
  // halting section, whose code must stay readable while the other part is programmed.
  assign halting_target = (32'(z_page) >= HALTING_SECTION_FIRST_PAGE);

  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    arm_cnt_d = arm_cnt_q;
    op_d = op_q;
    page_d = page_q;
    ie_d = ie_q;
    busy_d = busy_q;
    stall_d = stall_q;
    erase_d = 1'b0;
    write_d = 1'b0;
    lock_d = lock_q;
    buf_load = 1'b0;
    buf_clear = 1'b0;
    tmr_start = 1'b0;
    if (i_ctrl_wr) begin
      ie_d = i_ctrl_wdata[`CTRL_IE_BIT];
    end
    case (state_q)
      ST_IDLE: begin
        // commands refused during EEPROM write
        // Only the enable bit arms; a write without it just updates the interrupt enable.
        if (i_ctrl_wr && !i_eeprom_write_busy && i_ctrl_wdata[`CTRL_EN_BIT]) begin
          cmd_d = i_ctrl_wdata[`CMD_W-1:0];
          arm_cnt_d = 3'h0;
          state_d = ST_ARMED;
        end
      end
      ST_ARMED: begin
        // EEPROM write cancels arming
        // Cancelling rather than waiting keeps a stale store from firing later.
        if (i_eeprom_write_busy) begin
          cmd_d = '0;
          state_d = ST_IDLE;
        end else if (i_spm) begin
          cmd_d = '0;
          state_d = ST_IDLE;
          case (cmd_q)
            `CMD_LOAD: begin
              buf_load = 1'b1;
            end
            `CMD_ERASE: begin
              // The command bits stay up while the timer runs, so software can poll them.
              cmd_d = cmd_q;
              page_d = z_page;
              op_d = OP_ERASE;
              erase_d = 1'b1;
              tmr_start = 1'b1;
              busy_d = 1'b1;
              stall_d = halting_target;
              state_d = ST_RUN;
            end
            `CMD_WRITE: begin
              cmd_d = cmd_q;
              page_d = z_page;
              op_d = OP_WRITE;
              write_d = 1'b1;
              tmr_start = 1'b1;
              busy_d = 1'b1;
              stall_d = halting_target;
              state_d = ST_RUN;
            end
            `CMD_LOCK: begin
              cmd_d = cmd_q;
              // pointer not used
              // Neither the latched page nor the buffer index is touched here.
              op_d = OP_LOCK;
              tmr_start = 1'b1;
              // zero data bit programs the lock
              // Bits only move from one to zero; nothing in this block unprograms a lock.
              lock_d = lock_q & i_r0[`LOCK_W-1:0];
              stall_d = 1'b0;
              state_d = ST_RUN;
            end
            `CMD_REEN: begin
              // Acting on the store, not on the control write, keeps one path for all commands.
              busy_d = 1'b0;
              buf_clear = 1'b1;
            end
            default: begin
              cmd_d = '0;
            end
          endcase
        // arming window expiry
        // The counter starts at zero on the write, so stores land in the four cycles after it.
        end else if (arm_cnt_q == (`ARM_WINDOW_CYC - 3'h1)) begin
          cmd_d = '0;
          state_d = ST_IDLE;
        end else begin
          arm_cnt_d = arm_cnt_q + 3'h1;
        end
      end
      ST_RUN: begin
        // operation length from timer
        // The timer length sets the minimum programming time; scale PROG_CYCLES to the clock.
        if (sif.tmr_done) begin
          cmd_d = '0;
          stall_d = 1'b0;
          buf_clear = (op_q == OP_WRITE);
          op_d = OP_NONE;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cmd_d = '0;
      end
    endcase

    // EEPROM write discards loaded words
    // Clearing only while a word is loaded is enough: an empty buffer has nothing to lose.
    if (i_eeprom_write_busy && sif.buf_any_loaded) begin
      buf_clear = 1'b1;
    end

    // level interrupt while enable is clear
    // Both come from the next values, so interrupt and status bits always change together.
    irq_d = ie_d && !cmd_d[`CTRL_EN_BIT];
    status_d = {ie_d, busy_d, 1'b0, cmd_d[4:0]};
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      cmd_q <= '0;
      arm_cnt_q <= 3'h0;
      op_q <= OP_NONE;
      page_q <= '0;
      ie_q <= 1'b0;
      busy_q <= 1'b0;
      stall_q <= 1'b0;
      erase_q <= 1'b0;
      write_q <= 1'b0;
      lock_q <= `LOCK_RESET;
      irq_q <= 1'b0;
      status_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      arm_cnt_q <= arm_cnt_d;
      op_q <= op_d;
      page_q <= page_d;
      ie_q <= ie_d;
      busy_q <= busy_d;
      stall_q <= stall_d;
      erase_q <= erase_d;
      write_q <= write_d;
      lock_q <= lock_d;
      irq_q <= irq_d;
      status_q <= status_d;
    end
  end

  // Buffer and timer hookup; the buffer reset also gives the clear on reset.
  // The word index needs no latch because a buffer load completes in one cycle.
  assign sif.buf_load = buf_load;
  assign sif.buf_idx = z_word;
  assign sif.buf_wdata = {i_r1, i_r0};
  assign sif.buf_clear = buf_clear;
  assign sif.buf_rd_idx = i_buf_rd_idx;
  assign sif.tmr_start = tmr_start;
  assign o_buf_rd_data = sif.buf_rd_data;

  // Read port state.
  logic [14:0] lpm_addr_q, lpm_addr_d;
  logic lpm_hi_q, lpm_hi_d;
  logic lpm_vld_q, lpm_vld_d;
  logic lpm_blk_q, lpm_blk_d;
  logic fl_blk_q, fl_blk_d;

  always_comb begin
    lpm_addr_d = lpm_addr_q;
    lpm_hi_d = lpm_hi_q;
    lpm_vld_d = 1'b0;
    lpm_blk_d = lpm_blk_q;
    if (i_lpm) begin
      lpm_addr_d = z_ptr[15:1];
      lpm_hi_d = z_ptr[0];
      lpm_vld_d = 1'b1;
      // read-while-write part unreadable while busy
      // The address still goes out; the array must drop the data while blocked is set.
      lpm_blk_d = busy_d && !halting_target;
    end
    // fuse and lock reads blocked during EEPROM write
    // The EEPROM busy level is on this clock already, so no synchroniser is needed.
    fl_blk_d = i_eeprom_write_busy;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lpm_addr_q <= 15'h0000;
      lpm_hi_q <= 1'b0;
      lpm_vld_q <= 1'b0;
      lpm_blk_q <= 1'b0;
      fl_blk_q <= 1'b0;
    end else begin
      lpm_addr_q <= lpm_addr_d;
      lpm_hi_q <= lpm_hi_d;
      lpm_vld_q <= lpm_vld_d;
      lpm_blk_q <= lpm_blk_d;
      fl_blk_q <= fl_blk_d;
    end
  end

  assign o_self_prog_ctrl_status = status_q;
  assign o_lpm_word_addr = lpm_addr_q;
  assign o_lpm_byte_hi = lpm_hi_q;
  assign o_lpm_valid = lpm_vld_q;
  assign o_lpm_blocked = lpm_blk_q;
  assign o_fuse_lock_read_block = fl_blk_q;
  assign o_flash_erase = erase_q;
  assign o_flash_write = write_q;
  assign o_flash_page = page_q;
  assign o_lock_bits = lock_q;
  assign o_cpu_stall = stall_q;
  assign o_prog_irq = irq_q;
endmodule

// ==== hw/flash_sp_consts.svh ====
// Shared constants for the flash self-programming sequencer.
`ifndef FLASH_SP_CONSTS_SVH
`define FLASH_SP_CONSTS_SVH

`define CTRL_EN_BIT 0
`define CTRL_ERASE_BIT 1
`define CTRL_WRITE_BIT 2
`define CTRL_LOCK_BIT 3
`define CTRL_REEN_BIT 4
`define CTRL_BUSY_BIT 6
`define CTRL_IE_BIT 7
`define CMD_W 6
`define CMD_LOAD 6'h01
`define CMD_ERASE 6'h03
`define CMD_WRITE 6'h05
`define CMD_LOCK 6'h09
`define CMD_REEN 6'h11
`define ARM_WINDOW_CYC 3'h4
`define CLK_MHZ 25
`define PROG_TIME_MIN_US 3700
`define PROG_CYCLES (`PROG_TIME_MIN_US * `CLK_MHZ)
`define LOCK_W 6
`define LOCK_RESET 6'h3F
`define WORD_BITS 6
`define HALTING_SECTION_FIRST_PAGE 448

`endif

// ==== hw/flash_sp_if.sv ====
// Internal carrier between the sequencer, its page buffer and its timer.
`timescale 1ns/100ps
interface flash_sp_if #(
  parameter int WORD_BITS = 6
);
  logic buf_load;
  logic [WORD_BITS-1:0] buf_idx;
  logic [15:0] buf_wdata;
  logic buf_clear;
  logic [WORD_BITS-1:0] buf_rd_idx;
  logic [15:0] buf_rd_data;
  logic buf_any_loaded;
  logic tmr_start;
  logic tmr_done;

  modport seq (
    output buf_load, buf_idx, buf_wdata, buf_clear, buf_rd_idx, tmr_start,
    input buf_rd_data, buf_any_loaded, tmr_done
  );
  modport pbuf (
    input buf_load, buf_idx, buf_wdata, buf_clear, buf_rd_idx,
    output buf_rd_data, buf_any_loaded
  );
  modport tmr (
    input tmr_start,
    output tmr_done
  );
endinterface

// ==== hw/flash_sp_page_buf.sv ====
// Temporary page buffer: one word per entry plus a loaded flag.
`timescale 1ns/100ps
module flash_sp_page_buf #(
  parameter int WORD_BITS = 6
) (
  input wire logic i_clk,
  input wire logic i_rst,
  flash_sp_if.pbuf bif
);
  localparam int DEPTH = 1 << WORD_BITS;

  logic [15:0] mem_q [DEPTH];
  logic [DEPTH-1:0] vld_q;
  logic [15:0] rd_q, rd_d;

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      logic [15:0] word_d;
      logic vld_d;
      always_comb begin
        word_d = mem_q[gi];
        vld_d = vld_q[gi];
        if (bif.buf_clear) begin
          word_d = 16'hFFFF;
          vld_d = 1'b0;
        end else if (bif.buf_load && (bif.buf_idx == WORD_BITS'(gi))) begin
          word_d = bif.buf_wdata;
          vld_d = 1'b1;
        end
      end
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          mem_q[gi] <= 16'hFFFF;
          vld_q[gi] <= 1'b0;
        end else begin
          mem_q[gi] <= word_d;
          vld_q[gi] <= vld_d;
        end
      end
    end
  endgenerate

  always_comb begin
    rd_d = mem_q[bif.buf_rd_idx];
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd_q <= 16'hFFFF;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign bif.buf_rd_data = rd_q;
  assign bif.buf_any_loaded = |vld_q;
endmodule

// ==== hw/flash_sp_pkg.sv ====
// Types of the flash self-programming sequencer.
package flash_sp_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_RUN = 2'b10
  } seq_state_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_ERASE = 2'b01,
    OP_WRITE = 2'b10,
    OP_LOCK = 2'b11
  } op_kind_t;
endpackage

// ==== hw/flash_sp_timer.sv ====
// Programming-time counter: one done pulse a fixed count after start.
`timescale 1ns/100ps
module flash_sp_timer #(
  parameter int PROG_CYCLES = 92500
) (
  input wire logic i_clk,
  input wire logic i_rst,
  flash_sp_if.tmr tif
);
  logic [31:0] cnt_q, cnt_d;
  logic done_q, done_d;

  always_comb begin
    cnt_d = cnt_q;
    done_d = 1'b0;
    if (tif.tmr_start) begin
      cnt_d = 32'(PROG_CYCLES);
    end else if (cnt_q != 32'h0) begin
      cnt_d = cnt_q - 32'h1;
      done_d = (cnt_q == 32'h1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= 32'h0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign tif.tmr_done = done_q;
endmodule
